// file: flash_seq.sv
// serial flash command sequencer: security register, block locks, reset
// assumes a host driving cs_n, sclk and si in single-bit mode 0 framing
//
// Function
// R01: program needs write enable latch set
// R02: program frame opcode address data, runs at deselect
// R03: write in progress high through program cycle
// R04: write enable latch clears before cycle ends; code clears it on the same clock that ends the cycle
// R05: security lock bit set blocks every program
// R06: sixteen pages, bits 11:8 page, 7:0 byte
// R07: read frame opcode address dummy then data
// R08: read address increments, wraps in 12 bits
// R09: protection select picks locks or protect bits
// R10: lock opcode plus address locks one block
// R11: unlock opcode plus address unlocks one block
// R12: lock read returns lock bit in LSB
// R13: global lock sets all, unlock clears all
// R14: reset aborts operation, clears volatile state; code keeps config and protect bits
// R15: reset needs enable frame directly before it
// R16: no command accepted during reset recovery
// R17: host quits quad modes before reset pair
// R18: host checks busy before issuing reset
// R19: parameter read opcode returns parameter table
// R20: delivered array reads ones, status zero
// R21: address 24 bit, 32 bit in 4-byte mode
// R22: every byte shifted most significant first
`include "flash_seq_cfg.svh"

module flash_seq (
   // core clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // serial link
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic si,
   output flash_seq_pkg::byte_t so_byte_q,
   output logic so_q,
   output logic so_oe_q,
   // status
   output logic write_in_progress_q,
   output logic protect_hit_q
);
   import flash_seq_pkg::*;

   // ****************************************
   // reset release
   // ****************************************
   logic rst_s1_q;
   logic rst_n_q;

   // two flops release the asynchronous reset
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rst_s1_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n_q <= rst_s1_q;
      end
   end

   // ****************************************
   // link clock domain
   // ****************************************
   logic [2:0] rx_cnt_q;
   logic [6:0] rx_sh_q;
   byte_t rx_byte_q;
   logic rx_tgl_q;
   logic [2:0] tx_cnt_q;
   byte_t tx_sh_q;
   logic tx_tgl_q;
   byte_t tx_next_q;
   logic tx_en_q;

   // input shift, bit count cleared while deselected
   always_ff @(posedge sclk or posedge cs_n) begin
      if (cs_n) begin
         rx_cnt_q <= 3'h0;
         rx_sh_q <= 7'h00;
      end else begin
         rx_cnt_q <= rx_cnt_q + 3'h1;
         rx_sh_q <= {rx_sh_q[5:0], si}; // R22
      end
   end

   // whole byte captured and flagged by toggle
   always_ff @(posedge sclk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         rx_byte_q <= 8'h00;
         rx_tgl_q <= 1'b0;
      end else if (rx_cnt_q == 3'h7) begin
         rx_byte_q <= {rx_sh_q, si}; // R22
         rx_tgl_q <= ~rx_tgl_q;
      end
   end

   // output shifter on falling edges, byte loaded at boundary
   // tx_next_q is settled long before the load it feeds
   always_ff @(negedge sclk or posedge cs_n or negedge rst_n_q) begin
      if (cs_n || !rst_n_q) begin
         tx_cnt_q <= 3'h0;
         tx_sh_q <= 8'h00;
         so_q <= 1'b0;
         so_oe_q <= 1'b0;
         so_byte_q <= 8'h00;
      end else begin
         tx_cnt_q <= tx_cnt_q + 3'h1;
         if (tx_cnt_q == 3'h7) begin
            tx_sh_q <= tx_next_q;
            so_q <= tx_next_q[7]; // R22 R07
            so_oe_q <= tx_en_q;
            so_byte_q <= tx_next_q;
         end else begin
            tx_sh_q <= {tx_sh_q[6:0], 1'b0};
            so_q <= tx_sh_q[6]; // R22
         end
      end
   end

   // load event toggle for the core pointer
   always_ff @(negedge sclk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         tx_tgl_q <= 1'b0;
      end else if (!cs_n && tx_cnt_q == 3'h7) begin
         tx_tgl_q <= ~tx_tgl_q;
      end
   end

   // ****************************************
   // crossings into core clock
   // ****************************************
   logic [2:0] cs_s_q;
   logic [2:0] rx_s_q;
   logic [2:0] tx_s_q;
   logic frame_end_q;
   logic frame_start;
   logic byte_evt;
   logic load_evt;

   // two flops each, third stage only for edge detect
   always_ff @(posedge core_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         cs_s_q <= 3'h7;
         rx_s_q <= 3'h0;
         tx_s_q <= 3'h0;
         frame_end_q <= 1'b0;
      end else begin
         cs_s_q <= {cs_s_q[1:0], cs_n};
         rx_s_q <= {rx_s_q[1:0], rx_tgl_q};
         tx_s_q <= {tx_s_q[1:0], tx_tgl_q};
         frame_end_q <= cs_s_q[1] & ~cs_s_q[2];
      end
   end

   assign frame_start = ~cs_s_q[1] & cs_s_q[2];
   assign byte_evt = rx_s_q[1] ^ rx_s_q[2];
   assign load_evt = tx_s_q[1] ^ tx_s_q[2];

   // ****************************************
   // decode helpers
   // ****************************************
   // commands that return data on the output
   function automatic logic is_read(input byte_t op);
      return op == `OP_RDSR || op == `OP_SR_READ || op == `OP_PARAM ||
             op == `OP_RDCFG || op == `OP_RD_LOCK;
   endfunction

   // commands with a dummy byte before data
   function automatic logic has_dummy(input byte_t op);
      return op == `OP_SR_READ || op == `OP_PARAM || op == `OP_RDCFG;
   endfunction

   // top blocks covered by the protect bits
   function automatic logic bp_covers(input byte_t blk,
                                      input logic [4:0] bp);
      logic [8:0] span;
      span = 9'h000;
      if (bp == 5'h00) begin
         return 1'b0;
      end
      if (bp > 5'h08) begin
         return 1'b1;
      end
      span = 9'h100 >> (4'h9 - bp[3:0]);
      return {1'b0, blk} >= (9'h100 - span);
   endfunction

   // parameter table, signature then erased
   function automatic byte_t param_byte(input logic [11:0] a);
      unique case (a)
         12'h000: return 8'h53;
         12'h001: return 8'h46;
         12'h002: return 8'h44;
         12'h003: return 8'h50;
         default: return `ERASED_BYTE;
      endcase
   endfunction

   // ****************************************
   // frame parsing
   // ****************************************
   seq_state_e state_q;
   byte_t opcode_q;
   logic [2:0] bi_q;
   logic [31:0] addr_q;
   byte_t col_q;
   byte_t data_q;
   byte_t blk_q;
   logic [11:0] rd_addr_q;
   logic data_phase_q;
   logic [255:0] pmask_q;
   byte_t pbuf [256];
   logic four_byte_q;
   logic [2:0] alen;
   logic going_data;

   assign alen = four_byte_q ? `ALEN_4B : `ALEN_3B; // R21
   assign going_data = byte_evt && bi_q == alen + 3'h1;

   // byte index, opcode, address, data capture per frame
   always_ff @(posedge core_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         bi_q <= 3'h0;
         opcode_q <= 8'h00;
         addr_q <= 32'h0;
         col_q <= 8'h00;
         data_q <= 8'h00;
         blk_q <= 8'h00;
         rd_addr_q <= 12'h000;
         data_phase_q <= 1'b0;
         pmask_q <= 256'h0;
      end else if (frame_start) begin
         bi_q <= 3'h0;
         addr_q <= 32'h0;
         data_phase_q <= 1'b0;
         // a status poll must not wipe the mask of a running copy
         if (state_q == ST_IDLE) begin
            pmask_q <= 256'h0;
         end
      end else begin
         if (byte_evt) begin
            if (bi_q != 3'h7) begin
               bi_q <= bi_q + 3'h1;
            end
            if (bi_q == 3'h0) begin
               opcode_q <= rx_byte_q;
            end
            if (bi_q != 3'h0 && bi_q <= alen) begin
               addr_q <= {addr_q[23:0], rx_byte_q}; // R21
            end
            if (bi_q == alen - 3'h2) begin
               blk_q <= rx_byte_q; // R10 R11 R12
            end
            if (bi_q == alen) begin
               col_q <= rx_byte_q;
               rd_addr_q <= {addr_q[3:0], rx_byte_q}; // R06 R07
            end
            if (opcode_q == `OP_SR_PROG && bi_q > alen &&
                state_q == ST_IDLE) begin
               pmask_q[col_q] <= 1'b1; // R02
               col_q <= col_q + 8'h01;
            end
            if ((opcode_q == `OP_WRSR && bi_q == 3'h1) ||
                (opcode_q == `OP_WRCFG && bi_q == alen + 3'h1)) begin
               data_q <= rx_byte_q;
            end
         end
         if (going_data && has_dummy(opcode_q)) begin
            data_phase_q <= 1'b1; // R07
         end
         // advance once a data byte has been loaded
         if (load_evt && (data_phase_q ||
             (going_data && has_dummy(opcode_q)))) begin
            rd_addr_q <= rd_addr_q + 12'h001; // R08
         end
      end
   end

   // program page buffer
   always_ff @(posedge core_clk) begin
      if (byte_evt && opcode_q == `OP_SR_PROG && bi_q > alen &&
          state_q == ST_IDLE) begin
         pbuf[col_q] <= rx_byte_q;
      end
   end

   // ****************************************
   // command execution and sequencer
   // ****************************************
   logic wel_q;
   logic rst_en_q;
   logic [255:0] lock_q;
   byte_t cfg_q;
   logic [4:0] bp_q;
   logic [3:0] page_q;
   logic [15:0] cnt_q;
   logic frame_bare;
   logic frame_addr;

   assign frame_bare = bi_q == 3'h1;
   assign frame_addr = bi_q == alen + 3'h1;

   // execution at deselect, sequencer for timed cycles
   always_ff @(posedge core_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         state_q <= ST_IDLE;
         wel_q <= 1'b0; // R20
         rst_en_q <= 1'b0;
         lock_q <= `LOCK_RESET;
         cfg_q <= `CFG_RESET;
         bp_q <= 5'h00; // R20
         four_byte_q <= 1'b0;
         page_q <= 4'h0;
         cnt_q <= 16'h0000;
      end else begin
         unique case (state_q)
            ST_PROG_COPY: begin
               cnt_q <= cnt_q + 16'h0001;
               if (cnt_q == 16'h00FF) begin
                  cnt_q <= 16'h0000;
                  state_q <= ST_PROG_WAIT;
               end
            end
            ST_PROG_WAIT: begin
               cnt_q <= cnt_q + 16'h0001;
               if (cnt_q == 16'(`PP_CYC - 1)) begin
                  wel_q <= 1'b0; // R04
                  state_q <= ST_IDLE; // R03
               end
            end
            ST_RST_WAIT: begin
               cnt_q <= cnt_q + 16'h0001;
               if (cnt_q == 16'(`RST_CYC - 1)) begin
                  state_q <= ST_IDLE; // R16
               end
            end
            ST_IDLE: begin
               cnt_q <= 16'h0000;
            end
         endcase
         if (frame_end_q && state_q != ST_RST_WAIT) begin // R16
            rst_en_q <= opcode_q == `OP_RST_EN && frame_bare; // R15
            if (opcode_q == `OP_RST && frame_bare && rst_en_q) begin
               // abort, clear latch, 4-byte mode and block locks; config and protect bits kept
               state_q <= ST_RST_WAIT; // R14 R15
               cnt_q <= 16'h0000;
               wel_q <= 1'b0; // R14
               four_byte_q <= 1'b0;
               lock_q <= `LOCK_RESET;
            end else if (state_q == ST_IDLE) begin
               unique case (opcode_q)
                  `OP_WRITE_ENABLE_COMMAND: if (frame_bare) wel_q <= 1'b1;
                  `OP_WRDI: if (frame_bare) wel_q <= 1'b0;
                  `OP_EN4B: if (frame_bare) four_byte_q <= 1'b1;
                  `OP_EX4B: if (frame_bare) four_byte_q <= 1'b0;
                  `OP_GLB_LOCK: if (frame_bare) lock_q <= '1; // R13
                  `OP_GLB_UNLOCK: if (frame_bare) lock_q <= '0; // R13
                  `OP_LOCK: if (frame_addr) lock_q[blk_q] <= 1'b1; // R10
                  `OP_UNLOCK: if (frame_addr) lock_q[blk_q] <= 1'b0; // R11
                  `OP_SR_PROG: begin
                     // latch checked, OTP lock honoured
                     if (wel_q && bi_q > alen && // R01 R02
                         !cfg_q[`CFG_SRLOCK_BIT] && // R05
                         addr_q[31:12] == 20'h0) begin // R06
                        page_q <= addr_q[11:8]; // R06
                        cnt_q <= 16'h0000;
                        state_q <= ST_PROG_COPY; // R02 R03
                     end
                  end
                  `OP_WRSR: begin
                     if (wel_q && bi_q > 3'h1) begin
                        bp_q <= data_q[`ST_BP_MSB:`ST_BP_LSB];
                        wel_q <= 1'b0;
                     end
                  end
                  `OP_WRCFG: begin
                     if (wel_q && bi_q > alen + 3'h1 &&
                         addr_q[11:0] == `CFG_OFFSET) begin
                        cfg_q <= data_q | (cfg_q & `CFG_OTP_MASK); // R05
                        wel_q <= 1'b0;
                     end
                  end
                  default: begin
                  end
               endcase
            end
         end
      end
   end

   // ****************************************
   // security register array
   // ****************************************
   // delivered erased, untouched by reset
   byte_t mem [4096] = '{default: `ERASED_BYTE}; // R20

   // program clears bits only, masked to loaded columns
   always_ff @(posedge core_clk) begin
      if (state_q == ST_PROG_COPY && pmask_q[cnt_q[7:0]]) begin
         mem[{page_q, cnt_q[7:0]}] <=
            mem[{page_q, cnt_q[7:0]}] & pbuf[cnt_q[7:0]]; // R02 R06
      end
   end

   // ****************************************
   // output byte selection and status
   // ****************************************
   logic write_in_progress;
   byte_t status;
   byte_t tx_d;
   logic lock_view;

   assign write_in_progress = state_q != ST_IDLE; // R03
   assign lock_view = cfg_q[`CFG_WPS_BIT] ? bp_covers(blk_q, bp_q)
                                          : lock_q[blk_q]; // R09

   // status byte, readable during the cycle
   always_comb begin
      status = 8'h00;
      status[`ST_WIP_BIT] = write_in_progress; // R03
      status[`ST_WEL_BIT] = wel_q;
      status[`ST_BP_MSB:`ST_BP_LSB] = bp_q;
   end

   // next byte for the shifter
   always_comb begin
      tx_d = status;
      if (opcode_q == `OP_RD_LOCK && bi_q != 3'h0) begin
         tx_d = {7'h00, lock_q[blk_q]}; // R12
      // fetch as soon as the address is in: the load after the dummy
      // byte comes before the dummy byte itself reaches this domain
      end else if (data_phase_q || (has_dummy(opcode_q) && bi_q > alen)) begin
         unique case (opcode_q)
            `OP_SR_READ: tx_d = mem[rd_addr_q]; // R07 R08
            `OP_PARAM: tx_d = param_byte(rd_addr_q); // R19
            `OP_RDCFG: tx_d = (rd_addr_q == `CFG_OFFSET) ? cfg_q : 8'h00;
            default: tx_d = status;
         endcase
      end
   end

   // registered toward the link domain and the status pins
   always_ff @(posedge core_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         tx_next_q <= 8'h00;
         tx_en_q <= 1'b0;
         write_in_progress_q <= 1'b0;
         protect_hit_q <= 1'b0;
      end else begin
         tx_next_q <= tx_d;
         tx_en_q <= state_q != ST_RST_WAIT &&
                    (bi_q == 3'h0 || is_read(opcode_q)); // R16
         write_in_progress_q <= write_in_progress; // R03
         protect_hit_q <= lock_view; // R09
      end
   end

endmodule // flash_seq

// file: flash_seq_cfg.svh
// constants of the serial flash command sequencer
// assumes a 20 MHz core clock and a single-bit serial link
`ifndef FLASH_SEQ_CFG_SVH
`define FLASH_SEQ_CFG_SVH

// command opcodes
`define OP_WRITE_ENABLE_COMMAND 8'h06
`define OP_WRDI 8'h04
`define OP_RDSR 8'h05
`define OP_WRSR 8'h01
`define OP_WRCFG 8'h71
`define OP_RDCFG 8'h65
`define OP_SR_PROG 8'h42
`define OP_SR_READ 8'h48
`define OP_LOCK 8'h36
`define OP_UNLOCK 8'h39
`define OP_RD_LOCK 8'h3D
`define OP_GLB_LOCK 8'h7E
`define OP_GLB_UNLOCK 8'h98
`define OP_RST_EN 8'h66
`define OP_RST 8'h99
`define OP_PARAM 8'h5A
`define OP_EN4B 8'hB7
`define OP_EX4B 8'hE9

// address lengths in bytes
`define ALEN_3B 3'h3
`define ALEN_4B 3'h4

// status byte fields
`define ST_WIP_BIT 0
`define ST_WEL_BIT 1
`define ST_BP_LSB 2
`define ST_BP_MSB 6

// protection_config register, lock reset and erased byte values
`define CFG_OFFSET 12'h004
`define CFG_WPS_BIT 2
`define CFG_SRLOCK_BIT 0
`define CFG_OTP_MASK 8'h01
`define CFG_RESET 8'h00
`define LOCK_RESET 256'h0
`define ERASED_BYTE 8'hFF

// timing, ns and derived core clock cycles
`define CORE_CLK_NS 50
`define T_PP_NS 20000
`define T_RST_NS 30000
`define PP_CYC ((`T_PP_NS + `CORE_CLK_NS - 1) / `CORE_CLK_NS)
`define RST_CYC ((`T_RST_NS + `CORE_CLK_NS - 1) / `CORE_CLK_NS)

`endif

// file: flash_seq_pkg.sv
// types of the serial flash command sequencer
// assumes flash_seq_cfg.svh for all numeric constants
package flash_seq_pkg;
   // internal operation sequencer
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_PROG_COPY,
      ST_PROG_WAIT,
      ST_RST_WAIT
   } seq_state_e;
   typedef logic [7:0] byte_t;
endpackage

// file: flash_seq_monitor.sv
// checker of the flash sequencer ports, bound to flash_seq
// assumes core_clk and sclk unrelated, cs_n high between frames
module flash_seq_monitor (
   // core side
   input wire logic core_clk,
   input wire logic resetn,
   // serial link
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic si,
   input wire flash_seq_pkg::byte_t so_byte_q,
   input wire logic so_q,
   input wire logic so_oe_q,
   // status
   input wire logic write_in_progress_q,
   input wire logic protect_hit_q
);
   timeunit 1ns;
   timeprecision 1ns;
   import flash_seq_pkg::*;
   logic [2:0] bit_cnt_q;
   logic [9:0] busy_cnt_q;
   // rising edges seen in the current byte
   always_ff @(posedge sclk or posedge cs_n) begin
      if (cs_n) bit_cnt_q <= 3'h0;
      else bit_cnt_q <= bit_cnt_q + 3'h1;
   end
   // length of the current busy period
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) busy_cnt_q <= 10'h000;
      else if (write_in_progress_q) busy_cnt_q <= busy_cnt_q + 10'h001;
      else busy_cnt_q <= 10'h000;
   end
   sequence busy_start_s;
      $rose(write_in_progress_q);
   endsequence
   sequence busy_hold_s;
      write_in_progress_q [*8];
   endsequence
   oe_idle_a: assert property (@(posedge core_clk) disable iff (!resetn)
      cs_n && $past(cs_n) |-> !so_oe_q) else $error("so driven idle");
   oe_frame_a: assert property (@(posedge core_clk) disable iff (!resetn)
      $rose(so_oe_q) |-> !cs_n) else $error("so enabled off frame");
   wip_start_a: assert property (@(posedge core_clk) disable iff (!resetn)
      busy_start_s |-> cs_n) else $error("busy began in a frame");
   wip_hold_a: assert property (@(posedge core_clk) disable iff (!resetn)
      busy_start_s |-> busy_hold_s) else $error("busy too short");
   wip_bound_a: assert property (@(posedge core_clk) disable iff (!resetn)
      busy_cnt_q <= 10'h2D0) else $error("busy too long");
   wip_boot_a: assert property (@(posedge core_clk) disable iff (!resetn)
      $rose(resetn) |-> !write_in_progress_q [*3]) else $error("busy at boot");
   hit_quiet_a: assert property (@(posedge core_clk) disable iff (!resetn)
      $changed(protect_hit_q) |-> $past(cs_n, 2)) else $error("hit moved");
   msb_first_a: assert property (@(posedge sclk) disable iff (!resetn || cs_n)
      so_oe_q |-> so_q == so_byte_q[3'h7 - bit_cnt_q])
      else $error("so bit order wrong");
endmodule // flash_seq_monitor

bind flash_seq flash_seq_monitor mon (.core_clk(core_clk), .resetn(resetn),
   .sclk(sclk), .cs_n(cs_n), .si(si), .so_byte_q(so_byte_q), .so_q(so_q),
   .so_oe_q(so_oe_q), .write_in_progress_q(write_in_progress_q),
   .protect_hit_q(protect_hit_q));

// file: flash_host_model.sv
// host controller model: single-bit mode 0 frames on the serial link
// assumes the bench fills tx and calls run; sclk still between frames
module flash_host_model (
   // serial link
   output logic sclk,
   output logic cs_n,
   output logic si,
   input wire logic so_q,
   input wire logic so_oe_q
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] tx [16];
   logic [7:0] rx [16];
   logic oe_seen;
   // idle link
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      si = 1'b0;
   end
   // one frame of n bytes at an 80 ns period, then a deselect gap
   task automatic run(input int n);
      cs_n = 1'b0;
      oe_seen = 1'b0;
      #40;
      for (int b = 0; b < n; b++) begin
         for (int i = 7; i >= 0; i--) begin
            si = tx[b][i];
            #40 sclk = 1'b1;
            rx[b][i] = so_q;
            oe_seen = oe_seen | so_oe_q;
            #40 sclk = 1'b0;
         end
      end
      #40 cs_n = 1'b1;
      si = ~si;
      #400;
   endtask
endmodule // flash_host_model

// file: tb_serial_flash_secreg_lock_reset.sv
// bench of the flash sequencer: security register, locks, reset
// assumes flash_host_model on the link and the bound monitor
`include "flash_seq_cfg.svh"
module tb_serial_flash_secreg_lock_reset;
   timeunit 1ns;
   timeprecision 1ns;
   import flash_seq_pkg::*;
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   wire sclk;
   wire cs_n;
   wire si;
   byte_t so_byte_q;
   logic so_q;
   logic so_oe_q;
   logic write_in_progress;
   logic hit;
   int miscompares = 0;
   int n_checks = 0;
   // design and host
   flash_seq DUT (.core_clk(core_clk), .resetn(resetn), .sclk(sclk),
      .cs_n(cs_n), .si(si), .so_byte_q(so_byte_q), .so_q(so_q),
      .so_oe_q(so_oe_q), .write_in_progress_q(write_in_progress), .protect_hit_q(hit));
   flash_host_model host (.sclk(sclk), .cs_n(cs_n), .si(si), .so_q(so_q),
      .so_oe_q(so_oe_q));
   always #25 core_clk = ~core_clk;
   // ******************
   // shared tasks
   // ******************
   task automatic end_sim;
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [7:0] seen,
      input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic frame(input logic [7:0] op, input logic [23:0] a,
      input logic [7:0] d, input int n);
      host.tx = '{0:op, 1:a[23:16], 2:a[15:8], 3:a[7:0], 4:d, default:8'h00};
      host.run(n);
   endtask
   task automatic status(input logic [7:0] exp);
      frame(`OP_RDSR, 24'h000000, 8'h00, 3);
      check("status", host.rx[2], exp);
   endtask
   task automatic lock_rd(input logic [23:0] a, input logic [7:0] exp);
      frame(`OP_RD_LOCK, a, 8'h00, 5);
      check("lock bit", host.rx[4], exp);
   endtask
   task automatic write_enable_command;
      frame(`OP_WRITE_ENABLE_COMMAND, 24'h000000, 8'h00, 1);
   endtask
   task automatic wait_idle;
      int i;
      for (i = 0; i < 2000 && write_in_progress !== 1'b0; i++) @(negedge core_clk);
      if (i == 2000) begin
         miscompares++;
         $display("CHECK FAILED busy wait expected 0 seen 1");
         end_sim;
      end
   endtask
   task automatic cfg_wr(input logic [7:0] d);
      write_enable_command;
      frame(`OP_WRCFG, 24'h000004, d, 5);
      wait_idle;
   endtask
   // ******************
   // scenarios
   // ******************
   task automatic t_boot;
      status(8'h00);
      frame(`OP_SR_READ, 24'h000123, 8'h00, 6);
      check("erased byte", host.rx[5], 8'hFF);
      frame(`OP_PARAM, 24'h000000, 8'h00, 9);
      check("param 0", host.rx[5], 8'h53);
      check("param 3", host.rx[8], 8'h50);
      $display("test boot done");
   endtask
   task automatic t_program;
      frame(`OP_SR_PROG, 24'h000000, 8'h69, 5);
      check("busy no latch", {7'h00, write_in_progress}, 8'h00);
      write_enable_command;
      frame(`OP_SR_PROG, 24'h000000, 8'h69, 5);
      check("busy", {7'h00, write_in_progress}, 8'h01);
      status(8'h03);
      wait_idle;
      status(8'h00);
      write_enable_command;
      frame(`OP_SR_PROG, 24'h000FFF, 8'h96, 5);
      wait_idle;
      frame(`OP_SR_READ, 24'h000FFE, 8'h00, 8);
      check("byte FFE", host.rx[5], 8'hFF);
      check("byte FFF", host.rx[6], 8'h96);
      check("wrap 000", host.rx[7], 8'h69);
      $display("test program done");
   endtask
   task automatic t_locks;
      cfg_wr(8'h00);
      frame(`OP_LOCK, 24'h020000, 8'h00, 4);
      lock_rd(24'h020000, 8'h01);
      check("hit locked", {7'h00, hit}, 8'h01);
      frame(`OP_UNLOCK, 24'h020000, 8'h00, 4);
      lock_rd(24'h020000, 8'h00);
      check("hit open", {7'h00, hit}, 8'h00);
      frame(`OP_GLB_LOCK, 24'h000000, 8'h00, 1);
      lock_rd(24'h7F0000, 8'h01);
      frame(`OP_GLB_UNLOCK, 24'h000000, 8'h00, 1);
      lock_rd(24'h7F0000, 8'h00);
      frame(`OP_GLB_LOCK, 24'h000000, 8'h00, 1);
      cfg_wr(8'h04);
      frame(`OP_RDCFG, 24'h000004, 8'h00, 6);
      check("config", host.rx[5], 8'h04);
      lock_rd(24'h020000, 8'h01);
      check("hit by bp", {7'h00, hit}, 8'h00);
      frame(`OP_EN4B, 24'h000000, 8'h00, 1);
      frame(`OP_RD_LOCK, 24'h000200, 8'h00, 6);
      check("lock 4 byte", host.rx[5], 8'h01);
      frame(`OP_EX4B, 24'h000000, 8'h00, 1);
      $display("test locks done");
   endtask
   task automatic t_reset;
      write_enable_command;
      frame(`OP_RST_EN, 24'h000000, 8'h00, 1);
      status(8'h02);
      frame(`OP_RST, 24'h000000, 8'h00, 1);
      check("reset split", {7'h00, write_in_progress}, 8'h00);
      status(8'h02);
      write_enable_command;
      frame(`OP_SR_PROG, 24'h000100, 8'h55, 5);
      frame(8'hFF, 24'h000000, 8'h00, 1);
      frame(`OP_RST_EN, 24'h000000, 8'h00, 1);
      frame(`OP_RST, 24'h000000, 8'h00, 1);
      check("recovery", {7'h00, write_in_progress}, 8'h01);
      frame(`OP_RDSR, 24'h000000, 8'h00, 3);
      check("ignored", {7'h00, host.oe_seen}, 8'h00);
      wait_idle;
      status(8'h00);
      lock_rd(24'h020000, 8'h00);
      $display("test reset done");
   endtask
   task automatic t_otp;
      cfg_wr(8'h01);
      write_enable_command;
      frame(`OP_SR_PROG, 24'h000200, 8'h00, 5);
      check("locked prog", {7'h00, write_in_progress}, 8'h00);
      frame(`OP_SR_READ, 24'h000200, 8'h00, 6);
      check("kept byte", host.rx[5], 8'hFF);
      $display("test otp done");
   endtask
   // reset, then the scenarios in order
   initial begin
      repeat (16) @(negedge core_clk);
      resetn = 1'b1;
      repeat (4) @(negedge core_clk);
      t_boot;
      t_program;
      t_locks;
      t_reset;
      t_otp;
      end_sim;
   end
endmodule // tb_serial_flash_secreg_lock_reset
